// file: global_clock_source_control.sv
// clock control block: source selection and gate for one global network
// assumes fabric controls arrive asynchronously and registers come over axi4-lite
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R1 - only one corner pin feeds; other stays GPIO
// R2 - dual-purpose pin source never feeds loop reference
// R3 - fabric source never feeds loop reference
// R4 - network feeds loop only from pin/loop
// R5 - dynamic select covers pins and loop outputs only
// R6 - fabric drives two-bit dynamic select
// R7 - static select locked once in user mode
// R8 - two of the adjacent loop outputs are candidates
// R9 - fabric enables or disables the network
// R10 - five outputs per loop, two reach network
// R11 - loop reference from configuration or manual switch
// R12 - smallest variants: networks 0 to 9 only
// R13 - block count limit 30 or 20 per family
// R14 - left side of transceiver family: no pins
// R15 - dedicated pin may carry clock or control
// R16 - unused dedicated pin goes to fabric unregistered
// R17 - pins and loops dynamic, fabric source static only
// R18 - enable sampled on falling clock edge
// R19 - fabric disables before switching sources
// R20 - each select value maps one fixed candidate
// R21 - output held low while disabled
module global_clock_source_control (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // axi4-lite write
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // candidate clock sources
    input wire logic [1:0] ded_clk_pin,
    input wire logic [4:0] loop_a_clk,
    input wire logic [4:0] loop_b_clk,
    input wire logic dual_purpose_clock_pin,
    input wire logic [1:0] corner_dual_purpose_clock_pin,
    input wire logic fabric_clk_src,
    // fabric controls
    input wire logic [1:0] clk_select,
    input wire logic net_enable,
    input wire logic user_mode,
    input wire logic loop_ref_switch,
    // outputs
    output logic global_clock_network,
    output logic loop_ref_clk,
    output logic net_is_control,
    output logic [1:0] ded_pin_to_fabric,
    output logic [1:0] corner_gpio_free
);
    // =====================================================================
    // declarations
    reg_port_if rp ();
    logic [31:0] cfg_r;
    logic [31:0] net_r;
    logic reject_r;
    logic [1:0] sel_s1_r;
    logic [1:0] sel_s2_r;
    logic [2:0] ctl_s1_r;
    logic [2:0] ctl_s2_r;
    logic [31:0] wmask;
    logic [31:0] cfg_nxt;
    logic [31:0] net_nxt;
    logic cfg_bad;
    logic net_bad;
    gcsc_pkg::static_src_e src_mode;
    gcsc_pkg::dyn_sel_e dyn_sel;
    logic [3:0] loop_pick0;
    logic [3:0] loop_pick1;
    logic [9:0] loop_all;
    logic [1:0] loop_cand;
    logic [1:0] ded_avail;
    logic dp_src;
    logic sel_clk;
    logic ref_ok;
    logic ena_s;
    logic user_s;
    logic ref_sw_s;
    logic [4:0] net_max;
    logic [4:0] block_max;
    logic [31:0] status;

    // =====================================================================
    // bus slave
    axil_reg_slave u_slave (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .rp(rp.slave)
    );

    // =====================================================================
    // synchronisers for fabric controls
    // two flops before any logic looks at the select
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_s1_r <= 2'h0;
            sel_s2_r <= 2'h0;
        end else begin
            sel_s1_r <= clk_select; // R6
            sel_s2_r <= sel_s1_r;
        end
    end

    // enable, user mode and manual reference switch
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_s1_r <= 3'h0;
            ctl_s2_r <= 3'h0;
        end else begin
            ctl_s1_r <= {loop_ref_switch, user_mode, net_enable};
            ctl_s2_r <= ctl_s1_r;
        end
    end

    assign ena_s = ctl_s2_r[0];
    assign user_s = ctl_s2_r[1];
    assign ref_sw_s = ctl_s2_r[2];

    // =====================================================================
    // register writes
    // byte lanes merge the written word into the held value
    assign wmask = {{8{rp.wr_strb[3]}}, {8{rp.wr_strb[2]}},
                    {8{rp.wr_strb[1]}}, {8{rp.wr_strb[0]}}};
    assign cfg_nxt = (cfg_r & ~wmask) | (rp.wr_data & wmask);
    assign net_nxt = (net_r & ~wmask) | (rp.wr_data & wmask);
    assign net_max = cfg_r[gcsc_pkg::CFG_SMALL_BIT] ? gcsc_pkg::NET_MAX_SMALL
                                                      : gcsc_pkg::NET_MAX_FULL;
    assign block_max = cfg_r[gcsc_pkg::CFG_GX_BIT] ? gcsc_pkg::BLOCKS_GX
                                                   : gcsc_pkg::BLOCKS_E;

    // configuration is frozen in user mode and must name real sources
    always_comb begin
        cfg_bad = 1'b0;
        if (user_s) begin
            cfg_bad = 1'b1; // R7
        end
        if (cfg_nxt[gcsc_pkg::CFG_SRC_LSB +: 2] == 2'b11) begin
            cfg_bad = 1'b1;
        end
        if (cfg_nxt[gcsc_pkg::CFG_LOOP0_LSB +: 4] > gcsc_pkg::LOOP_OUT_MAX ||
            cfg_nxt[gcsc_pkg::CFG_LOOP1_LSB +: 4] > gcsc_pkg::LOOP_OUT_MAX) begin
            cfg_bad = 1'b1; // R10
        end
    end

    // network index and block index bounds
    always_comb begin
        net_bad = user_s;
        if (net_nxt[gcsc_pkg::NET_INDEX_LSB +: 5] > net_max) begin
            net_bad = 1'b1; // R12
        end
        if (net_nxt[gcsc_pkg::NET_BLOCK_LSB +: 5] >= block_max) begin
            net_bad = 1'b1; // R13
        end
    end

    // decode and error answer for writes
    always_comb begin
        unique case (rp.wr_addr)
            gcsc_pkg::ADDR_CFG: rp.wr_err = cfg_bad;
            gcsc_pkg::ADDR_NET: rp.wr_err = net_bad;
            gcsc_pkg::ADDR_STATUS: rp.wr_err = 1'b0;
            default: rp.wr_err = 1'b1;
        endcase
    end

    // configuration register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= gcsc_pkg::CFG_RESET;
        end else if (rp.wr_en && rp.wr_addr == gcsc_pkg::ADDR_CFG && !cfg_bad) begin
            cfg_r <= cfg_nxt; // R7
        end
    end

    // network register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            net_r <= gcsc_pkg::NET_RESET;
        end else if (rp.wr_en && rp.wr_addr == gcsc_pkg::ADDR_NET && !net_bad) begin
            net_r <= net_nxt; // R12
        end
    end

    // sticky reject flag: a new reject wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reject_r <= 1'b0;
        end else if (rp.wr_en && rp.wr_err) begin
            reject_r <= 1'b1;
        end else if (rp.wr_en && rp.wr_addr == gcsc_pkg::ADDR_STATUS &&
                     rp.wr_strb[0] && rp.wr_data[gcsc_pkg::ST_REJECT_BIT]) begin
            reject_r <= 1'b0;
        end
    end

    // =====================================================================
    // register reads
    assign status = {24'h00_0000, src_mode, reject_r, ref_ok, user_s, ena_s, sel_s2_r};

    // read decode, unmapped answers with an error and zero
    always_comb begin
        rp.rd_err = 1'b0;
        unique case (rp.rd_addr)
            gcsc_pkg::ADDR_CFG: rp.rd_data = cfg_r;
            gcsc_pkg::ADDR_NET: rp.rd_data = net_r;
            gcsc_pkg::ADDR_STATUS: rp.rd_data = status;
            default: begin
                rp.rd_data = 32'h0000_0000;
                rp.rd_err = 1'b1;
            end
        endcase
    end

    // =====================================================================
    // candidate sources
    assign src_mode = gcsc_pkg::static_src_e'(cfg_r[gcsc_pkg::CFG_SRC_LSB +: 2]);
    assign dyn_sel = gcsc_pkg::dyn_sel_e'(sel_s2_r);
    assign loop_pick0 = cfg_r[gcsc_pkg::CFG_LOOP0_LSB +: 4];
    assign loop_pick1 = cfg_r[gcsc_pkg::CFG_LOOP1_LSB +: 4];
    assign loop_all = {loop_b_clk, loop_a_clk}; // R10
    assign loop_cand[0] = loop_all[loop_pick0]; // R8
    assign loop_cand[1] = loop_all[loop_pick1]; // R8

    // left side of the transceiver family has no dedicated pins
    assign ded_avail = (cfg_r[gcsc_pkg::CFG_GX_BIT] &&
                        cfg_r[gcsc_pkg::CFG_SIDE_LSB +: 2] == gcsc_pkg::SIDE_LEFT)
                       ? 2'h0 : ded_clk_pin; // R14

    // one dual-purpose input: plain pin or one of the corner pair
    always_comb begin
        if (cfg_r[gcsc_pkg::CFG_DP_CORNER_BIT]) begin
            dp_src = corner_dual_purpose_clock_pin[cfg_r[gcsc_pkg::CFG_CORNER_BIT]]; // R1
        end else begin
            dp_src = dual_purpose_clock_pin;
        end
    end

    // the corner pin not picked is left free for general use
    always_comb begin
        corner_gpio_free = 2'h3;
        if (cfg_r[gcsc_pkg::CFG_DP_CORNER_BIT]) begin
            corner_gpio_free[cfg_r[gcsc_pkg::CFG_CORNER_BIT]] = 1'b0; // R1
        end
    end

    // =====================================================================
    // source multiplexer
    // run-time select only steers pins and loop outputs
    always_comb begin
        sel_clk = 1'b0;
        unique case (src_mode)
            gcsc_pkg::SRC_DYNAMIC: begin
                unique case (dyn_sel) // R5
                    gcsc_pkg::DYN_PIN0: sel_clk = ded_avail[0]; // R20
                    gcsc_pkg::DYN_PIN1: sel_clk = ded_avail[1]; // R20
                    gcsc_pkg::DYN_LOOP0: sel_clk = loop_cand[0]; // R20
                    gcsc_pkg::DYN_LOOP1: sel_clk = loop_cand[1]; // R20
                endcase
            end
            gcsc_pkg::SRC_DUAL_PIN: sel_clk = dp_src; // R17
            gcsc_pkg::SRC_FABRIC: sel_clk = fabric_clk_src; // R17
            default: sel_clk = 1'b0;
        endcase
    end

    // gate with a falling-edge sampled enable
    clock_gate_cell u_gate (
        .clk_in(sel_clk),
        .arst_n(arst_n),
        .en(ena_s), // R9 R21
        .clk_out(global_clock_network) // R18
    );

    // =====================================================================
    // loop reference and side outputs
    assign ref_ok = (src_mode == gcsc_pkg::SRC_DYNAMIC); // R4

    // reference is the network only when it comes from pins or loops
    always_comb begin
        logic use_net;
        use_net = cfg_r[gcsc_pkg::CFG_REF_MANUAL_BIT] ? ref_sw_s
                                                      : cfg_r[gcsc_pkg::CFG_REF_STATIC_BIT];
        if (use_net) begin
            loop_ref_clk = ref_ok ? global_clock_network : 1'b0; // R2 R3
        end else begin
            loop_ref_clk = ded_avail[0]; // R11
        end
    end

    // pins not feeding the network pass straight to fabric, unregistered
    always_comb begin
        ded_pin_to_fabric = ded_avail; // R16
        if (src_mode == gcsc_pkg::SRC_DYNAMIC && !sel_s2_r[1]) begin
            ded_pin_to_fabric[sel_s2_r[0]] = 1'b0;
        end
    end

    assign net_is_control = cfg_r[gcsc_pkg::CFG_CTRL_MODE_BIT]; // R15

    // =====================================================================
    // checks
    a_cfg_frozen: assert property (@(posedge core_clk) disable iff (!arst_n) // R7
        user_s |=> $stable(cfg_r))
        else $error("configuration changed in user mode");
    a_net_bound: assert property (@(posedge core_clk) disable iff (!arst_n) // R12
        cfg_r[gcsc_pkg::CFG_SMALL_BIT] && rp.wr_en && rp.wr_addr == gcsc_pkg::ADDR_NET
        && net_nxt[4:0] > 5'h09 |=> $stable(net_r))
        else $error("network above nine accepted");
    a_block_bound: assert property (@(posedge core_clk) disable iff (!arst_n) // R13
        net_r[gcsc_pkg::NET_BLOCK_LSB +: 5] < 5'h1E)
        else $error("block index beyond limit");
    a_fabric_ref: assert property (@(posedge core_clk) disable iff (!arst_n) // R3
        src_mode == gcsc_pkg::SRC_FABRIC && cfg_r[gcsc_pkg::CFG_REF_STATIC_BIT]
        && !cfg_r[gcsc_pkg::CFG_REF_MANUAL_BIT] |-> !loop_ref_clk)
        else $error("fabric source reached loop reference");
    a_dual_ref: assert property (@(posedge core_clk) disable iff (!arst_n) // R2
        src_mode == gcsc_pkg::SRC_DUAL_PIN |-> !ref_ok)
        else $error("dual-purpose source allowed as reference");
    a_sel_sync: assert property (@(posedge core_clk) disable iff (!arst_n) // R6
        sel_s2_r == $past(clk_select, 2))
        else $error("select not two flops behind pin");
    a_gate_low: assert property (@(posedge core_clk) disable iff (!arst_n) // R21
        !ena_s ##1 !ena_s[*3] |-> !global_clock_network)
        else $error("network not held low while disabled");
    a_left_pins: assert property (@(posedge core_clk) disable iff (!arst_n) // R14
        cfg_r[gcsc_pkg::CFG_GX_BIT] && cfg_r[17:16] == 2'h0 |-> ded_pin_to_fabric == 2'h0)
        else $error("left-side pins present");
    a_corner_one: assert property (@(posedge core_clk) disable iff (!arst_n) // R1
        cfg_r[gcsc_pkg::CFG_DP_CORNER_BIT] |-> $countones(corner_gpio_free) == 1)
        else $error("corner pin pairing broken");
endmodule : global_clock_source_control
`default_nettype wire

// file: gcsc_pkg.sv
// package of constants for the global clock source control block
// assumes a 32-bit register bus whose registers sit at aligned word offsets
package gcsc_pkg;
    // =====================================================================
    // register map
    localparam logic [3:0] ADDR_CFG = 4'h0;
    localparam logic [3:0] ADDR_NET = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    // =====================================================================
    // configuration register fields
    localparam int CFG_SRC_LSB = 0;
    localparam int CFG_CORNER_BIT = 2;
    localparam int CFG_LOOP0_LSB = 3;
    localparam int CFG_LOOP1_LSB = 7;
    localparam int CFG_REF_STATIC_BIT = 11;
    localparam int CFG_REF_MANUAL_BIT = 12;
    localparam int CFG_CTRL_MODE_BIT = 13;
    localparam int CFG_GX_BIT = 14;
    localparam int CFG_SMALL_BIT = 15;
    localparam int CFG_SIDE_LSB = 16;
    localparam int CFG_DP_CORNER_BIT = 18;
    localparam logic [31:0] CFG_RESET = 32'h0000_0080;
    // =====================================================================
    // network register fields
    localparam int NET_INDEX_LSB = 0;
    localparam int NET_BLOCK_LSB = 8;
    localparam logic [31:0] NET_RESET = 32'h0000_0000;
    // =====================================================================
    // status register fields
    localparam int ST_DYN_LSB = 0;
    localparam int ST_ENA_BIT = 2;
    localparam int ST_USER_BIT = 3;
    localparam int ST_REF_OK_BIT = 4;
    localparam int ST_REJECT_BIT = 5;
    localparam int ST_SRC_LSB = 6;
    // =====================================================================
    // limits
    localparam logic [3:0] LOOP_OUT_MAX = 4'h9;
    localparam logic [4:0] NET_MAX_SMALL = 5'h09;
    localparam logic [4:0] NET_MAX_FULL = 5'h13;
    localparam logic [4:0] BLOCKS_GX = 5'h1E;
    localparam logic [4:0] BLOCKS_E = 5'h14;
    localparam int LOOP_OUTPUTS = 5;
    localparam logic [1:0] SIDE_LEFT = 2'h0;
    // =====================================================================
    // modes
    typedef enum logic [1:0] {
        SRC_DYNAMIC = 2'b00,
        SRC_DUAL_PIN = 2'b01,
        SRC_FABRIC = 2'b10
    } static_src_e;
    typedef enum logic [1:0] {
        DYN_PIN0 = 2'b00,
        DYN_PIN1 = 2'b01,
        DYN_LOOP0 = 2'b10,
        DYN_LOOP1 = 2'b11
    } dyn_sel_e;
endpackage : gcsc_pkg

// file: reg_port_if.sv
// interface carrying register accesses from the bus slave to the block
// assumes both ends run on core_clk
`timescale 1ns/1ns
`default_nettype none
interface reg_port_if;
    logic wr_en;
    logic [3:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic [3:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                   input wr_err, rd_data, rd_err);
    modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                  output wr_err, rd_data, rd_err);
endinterface : reg_port_if
`default_nettype wire

// file: axil_reg_slave.sv
// axi4-lite slave that turns bus transfers into register port accesses
// assumes one clock, active-low async reset, one outstanding access per direction
`timescale 1ns/1ns
`default_nettype none
module axil_reg_slave (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // write address and data
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read address and data
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // register side
    reg_port_if.slave rp
);
    logic aw_held_r;
    logic w_held_r;
    logic [3:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;

    // accept address and data in any order, then commit both at once
    assign awready = !aw_held_r && !bvalid;
    assign wready = !w_held_r && !bvalid;
    assign rp.wr_en = aw_held_r && w_held_r && !bvalid;
    assign rp.wr_addr = awaddr_r;
    assign rp.wr_data = wdata_r;
    assign rp.wr_strb = wstrb_r;
    assign rp.rd_addr = araddr;
    assign arready = !rvalid;

    // write channel holding and response
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 4'h0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
        end else begin
            if (awvalid && awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= awaddr;
            end
            if (wvalid && wready) begin
                w_held_r <= 1'b1;
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
            if (rp.wr_en) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid <= 1'b1;
                bresp <= rp.wr_err ? 2'h2 : 2'h0;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read channel, data captured with the address
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'h0;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rp.rd_data;
            rresp <= rp.rd_err ? 2'h2 : 2'h0;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule : axil_reg_slave
`default_nettype wire

// file: clock_gate_cell.sv
// network gate: enable sampled on the falling edge of the clock it gates
// assumes en is already stable relative to clk_in within half a period
`timescale 1ns/1ns
`default_nettype none
module clock_gate_cell (
    // clock to gate
    input wire logic clk_in,
    input wire logic arst_n,
    // enable and gated clock
    input wire logic en,
    output logic clk_out
);
    logic en_q_r;

    // falling-edge sample so a change never cuts a high phase short
    always_ff @(negedge clk_in or negedge arst_n) begin
        if (!arst_n) begin
            en_q_r <= 1'b0;
        end else begin
            en_q_r <= en;
        end
    end

    assign clk_out = clk_in & en_q_r;
endmodule : clock_gate_cell
`default_nettype wire

// file: fabric_ctrl_model.sv
// fabric logic model driving the dynamic select and network enable
// assumes the bench asks for a select and enable on want_sel and want_en
`timescale 1ns/1ns
`default_nettype none
module fabric_ctrl_model (
    // clock
    input wire logic core_clk,
    // requests from the bench
    input wire logic [1:0] want_sel,
    input wire logic want_en,
    // controls into the block
    output logic [1:0] clk_select,
    output logic net_enable
);
    int hold = 0;
    initial clk_select = 2'h0;
    initial net_enable = 1'b0;
    // =====================================================================
    // switch only while the network is gated off, and wait out the sync
    always @(posedge core_clk) begin
        if (want_sel !== clk_select) begin
            if (net_enable) begin
                net_enable <= 1'b0;
                hold <= 8;
            end else if (hold > 0) begin
                hold <= hold - 1;
            end else begin
                clk_select <= want_sel;
            end
        end else if (hold > 0) begin
            hold <= hold - 1;
        end else begin
            net_enable <= want_en;
        end
    end
endmodule : fabric_ctrl_model
`default_nettype wire

// file: global_clock_source_control_test.sv
// testbench for the global clock source control block
// assumes candidate clocks with even half periods so odd-ns samples avoid edges
`timescale 1ns/1ns
`default_nettype none
module global_clock_source_control_test;
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, a); end end
    int errors = 0;
    int cmp_count = 0;
    int n = 0;
    logic core_clk = 0, arst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic rready = 0, fab = 0, want_en = 0, user_mode = 0, awready, wready, bvalid;
    logic arready, rvalid, gcn, lref, net_enable;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] ded_clk_pin = 2'h0, want_sel = 2'h0, bresp, rresp, clk_select, pin_fab;
    logic [4:0] loop_a_clk = 5'h00;
    wire logic [4:0] srcs;
    assign srcs = {fab, loop_a_clk[1], loop_a_clk[0], ded_clk_pin};
    // =====================================================================
    // clocks
    always #20 core_clk = ~core_clk;
    always #6 ded_clk_pin[0] = ~ded_clk_pin[0];
    always #12 ded_clk_pin[1] = ~ded_clk_pin[1];
    always #8 loop_a_clk[0] = ~loop_a_clk[0];
    always #10 loop_a_clk[1] = ~loop_a_clk[1];
    always #14 fab = ~fab;
    global_clock_source_control i_global_clock_source_control (.core_clk(core_clk),
        .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .ded_clk_pin(ded_clk_pin), .loop_a_clk(loop_a_clk), .loop_b_clk(5'h00),
        .dual_purpose_clock_pin(1'b0), .corner_dual_purpose_clock_pin(2'h0),
        .fabric_clk_src(fab), .clk_select(clk_select), .net_enable(net_enable),
        .user_mode(user_mode), .loop_ref_switch(1'b0), .global_clock_network(gcn),
        .loop_ref_clk(lref), .net_is_control(), .ded_pin_to_fabric(pin_fab),
        .corner_gpio_free());
    fabric_ctrl_model i_fabric_ctrl_model (.core_clk(core_clk), .want_sel(want_sel),
        .want_en(want_en), .clk_select(clk_select), .net_enable(net_enable));
    // =====================================================================
    // verdict and bounded clock step
    task end_of_test;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    task tick;
        @(posedge core_clk);
        n++;
        if (n > 200) begin
            errors++;
            end_of_test();
        end
    endtask : tick
    // =====================================================================
    // axi4-lite write and read
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er,
                      input string nm);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            tick();
            aw = aw | awready;
            w = w | wready;
            awvalid <= !aw;
            wvalid <= !w;
        end
        while (bvalid !== 1'b1) tick();
        `CHK(nm, er, bresp)
        bready <= 1'b0;
        tick();
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er,
                      input string nm);
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do tick(); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) tick();
        `CHK(nm, ed, rdata)
        `CHK(nm, er, rresp)
        rready <= 1'b0;
        tick();
    endtask : rd
    // =====================================================================
    // fabric requests and network sampling
    task automatic set(input logic [1:0] s, input logic e);
        n = 0;
        want_sel <= s;
        want_en <= e;
        tick();
        while (clk_select !== s || net_enable !== e) tick();
        repeat (6) tick(); // two-flop sync plus the falling-edge gate flop
    endtask : set
    task automatic chk_net(input int src, input string nm);
        n = 0;
        repeat (6) begin
            tick();
            #3;
            `CHK(nm, (src < 0) ? 1'b0 : srcs[src], gcn)
        end
    endtask : chk_net
    // =====================================================================
    // main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        tick();
        rd(gcsc_pkg::ADDR_CFG, gcsc_pkg::CFG_RESET, 2'h0, "cfg_rst");
        rd(gcsc_pkg::ADDR_NET, gcsc_pkg::NET_RESET, 2'h0, "net_rst");
        rd(4'hC, 32'h0, 2'h2, "unmapped");
        for (int s = 0; s < 4; s++) begin
            set(s[1:0], 1'b1);
            chk_net(s, "net_follow");
        end
        set(2'h3, 1'b0);
        chk_net(-1, "net_off");
        set(2'h0, 1'b1);
        #3;
        `CHK("pin_fabric", {ded_clk_pin[1], 1'b0}, pin_fab)
        `CHK("ref_pin", ded_clk_pin[0], lref)
        wr(gcsc_pkg::ADDR_CFG, 32'h0000_0880, 2'h0, "cfg_ref");
        #3;
        `CHK("ref_net", ded_clk_pin[0], lref)
        wr(gcsc_pkg::ADDR_CFG, 32'h0000_0882, 2'h0, "cfg_fab");
        chk_net(4, "net_fabric");
        `CHK("ref_fab", 1'b0, lref)
        wr(gcsc_pkg::ADDR_CFG, 32'h0000_0003, 2'h2, "cfg_bad");
        rd(gcsc_pkg::ADDR_CFG, 32'h0000_0882, 2'h0, "cfg_keep");
        wr(gcsc_pkg::ADDR_CFG, 32'h0000_8080, 2'h0, "cfg_small");
        wr(gcsc_pkg::ADDR_NET, 32'h0000_000A, 2'h2, "net_big");
        wr(gcsc_pkg::ADDR_NET, 32'h0000_0009, 2'h0, "net_max");
        rd(gcsc_pkg::ADDR_NET, 32'h0000_0009, 2'h0, "net_rd");
        user_mode <= 1'b1;
        repeat (3) tick();
        wr(gcsc_pkg::ADDR_CFG, 32'h0000_0080, 2'h2, "cfg_locked");
        rd(gcsc_pkg::ADDR_CFG, 32'h0000_8080, 2'h0, "cfg_frozen");
        rd(gcsc_pkg::ADDR_STATUS, 32'h0000_003C, 2'h0, "status");
        wr(gcsc_pkg::ADDR_STATUS, 32'h0000_0020, 2'h0, "st_clr");
        rd(gcsc_pkg::ADDR_STATUS, 32'h0000_001C, 2'h0, "st_rd");
        end_of_test();
    end
endmodule : global_clock_source_control_test
`default_nettype wire
